// ==== src/wdi_defs.svh ====
// Purpose: Offsets, field positions, reset values and timing counts of the watchdog block
// Assumes: Byte-wide registers on a 17-bit byte address, 100 MHz clock
// Notes: Included by bare name; definitions only
//
// Behaviour
// - Timeout multiplier is low six bits
// - Each unit is one 31.25 ms tick
// - Range one tick up to 3Fh ticks
// - Multiplier zero disables the watchdog
// - Lock set keeps multiplier unchanged on writes
// - Multiplier writable only if lock already clear
// - Enabled watchdog expiry drives pin and flag
// - Disabled watchdog expiry sets flag only
// - Enabled alarm match drives pin and flag
// - Disabled alarm match sets flag only
// - Enabled power failure drives pin and flag
// - Disabled power failure sets flag only
// - Polarity bit: push-pull high or open-drain low
`ifndef WDI_DEFS_SVH
`define WDI_DEFS_SVH

// Register byte addresses
`define WDI_ADDR_W 17
`define WDI_ADDR_INT 17'h1FFF6
`define WDI_ADDR_DOG 17'h1FFF7
`define WDI_ADDR_STAT 17'h1FFE0
`define WDI_ADDR_MASK 17'h1FFE1

// Watchdog control fields
`define WDI_DOG_STROBE 7
`define WDI_DOG_LOCK 6
`define WDI_DOG_MULT_HI 5
`define WDI_DOG_MULT_LO 0

// Interrupt control fields
`define WDI_INT_DOG_EN 7
`define WDI_INT_ALM_EN 6
`define WDI_INT_PF_EN 5
`define WDI_INT_BATT 4
`define WDI_INT_POL 3
`define WDI_INT_PULSE 2

// Status and mask fields
`define WDI_EV_DOG 2
`define WDI_EV_ALM 1
`define WDI_EV_PF 0

// Reset values
`define WDI_RST_INT 8'h00
`define WDI_RST_DOG 8'h00
`define WDI_RST_MASK 3'h7

// Timing: tick period in ns and clock period in ns
`define WDI_TICK_NS 31250000
`define WDI_CLK_NS 10
`define WDI_TICK_CYC (`WDI_TICK_NS / `WDI_CLK_NS)

`endif

// ==== src/wdi_pkg.sv ====
// Purpose: Types shared by the watchdog block modules
// Assumes: Nothing beyond the defs header
// Notes: Never imported; referenced with the package scope
package wdi_pkg;
    // Timeout multiplier in ticks
    typedef logic [5:0] wdi_mult_t;
    // Interrupt pin drive style
    typedef enum logic [0:0]
    {
        WDI_PIN_OD = 1'b0,
        WDI_PIN_PP = 1'b1
    } wdi_pin_t;
    // One bit per event source, dog high
    typedef logic [2:0] wdi_ev_t;
endpackage

// ==== src/wdi_tick.sv ====
// Purpose: Divides the system clock down to the 32 Hz watchdog tick
// Assumes: CYC fits in 22 bits
// Notes: Restart zeroes the count so a fresh period starts
module wdi_tick #(
    parameter int unsigned CYC = 3125000
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    wdi_tick_if.gen tk
);
    localparam logic [21:0] LAST = 22'(CYC - 1);
    logic [21:0] cnt_q; // Cycle count inside a period
    logic [21:0] cnt_d;
    logic tick_q; // Registered tick pulse
    logic tick_d;

    // Next count and tick
    always_comb
    begin
        cnt_d = cnt_q + 22'h000001;
        tick_d = 1'b0;
        if (tk.restart)
        begin
            cnt_d = 22'h000000;
        end
        else if (cnt_q == LAST)
        begin
            cnt_d = 22'h000000;
            tick_d = 1'b1;
        end
    end

    // Register state
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            cnt_q <= 22'h000000;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tk.tick = tick_q;
endmodule

// ==== src/wdi_tick_if.sv ====
// Purpose: Carries the tick pulse and its restart between prescaler and core
// Assumes: Both ends on the same clock
// Notes: Restart is a one-cycle request
interface wdi_tick_if;
    logic restart; // Realign prescaler to a fresh period
    logic tick; // One-cycle pulse every tick period
    modport gen(input restart, output tick);
    modport use_side(output restart, input tick);
endinterface

// ==== src/wdi_top.sv ====
// Purpose: Watchdog timer with interrupt enables and a shared interrupt pin
// Assumes: Host strobes are one cycle, synchronous to i_clk
// Notes: Read data appear in the cycle after the read strobe only
`include "wdi_defs.svh"

module wdi_top #(
    parameter int unsigned TICK_CYC = `WDI_TICK_CYC
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [16:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_alarm_match,
    input wire logic i_powerfail,
    output logic o_irq,
    output logic o_int_o,
    output logic o_int_oe,
    output logic o_batt_alarm_en,
    output logic o_int_pulse_mode
);
    // Register selects
    logic sel_int; // Interrupt control hit
    logic sel_dog; // Watchdog control hit
    logic sel_stat; // Status hit
    logic sel_mask; // Mask hit

    // Control registers
    logic [7:0] intc_q; // Interrupt control, low two bits always zero
    logic [7:0] intc_d;
    wdi_pkg::wdi_mult_t mult_q; // Timeout multiplier in ticks
    wdi_pkg::wdi_mult_t mult_d;
    logic lock_q; // Timeout write lock
    logic lock_d;
    wdi_pkg::wdi_mult_t count_q; // Ticks left before expiry
    wdi_pkg::wdi_mult_t count_d;
    wdi_pkg::wdi_ev_t stat_q; // Sticky event flags
    wdi_pkg::wdi_ev_t stat_d;
    wdi_pkg::wdi_ev_t mask_q; // Interrupt mask, one enables
    wdi_pkg::wdi_ev_t mask_d;
    logic [7:0] rdata_q; // Registered read data
    logic [7:0] rdata_d;

    // Derived signals
    logic dog_wr; // Write to watchdog control
    logic dog_strobe; // Restart request from software
    logic dog_expire; // One-cycle expiry event
    wdi_pkg::wdi_ev_t events; // Raw event pulses this cycle
    wdi_pkg::wdi_ev_t enables; // Per-source pin enables
    logic pin_active; // Interrupt pin wants to assert
    wdi_pkg::wdi_pin_t pin_mode; // Pin drive style

    wdi_tick_if tk();

    // Prescaler shares one restart with the core so a strobe starts a full tick
    wdi_tick #(
        .CYC(TICK_CYC)
    ) u_tick (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .tk(tk)
    );

    // Address decode
    always_comb
    begin
        sel_int = (i_addr == `WDI_ADDR_INT);
        sel_dog = (i_addr == `WDI_ADDR_DOG);
        sel_stat = (i_addr == `WDI_ADDR_STAT);
        sel_mask = (i_addr == `WDI_ADDR_MASK);
        dog_wr = i_wr && sel_dog;
        dog_strobe = dog_wr && i_wdata[`WDI_DOG_STROBE];
    end

    // Watchdog control: lock first, multiplier guarded by the old lock
    always_comb
    begin
        lock_d = lock_q;
        mult_d = mult_q;
        if (dog_wr)
        begin
            lock_d = i_wdata[`WDI_DOG_LOCK];
            // Old lock value is used, so clearing and loading need two writes
            if (!lock_q)
            begin
                mult_d = i_wdata[`WDI_DOG_MULT_HI:`WDI_DOG_MULT_LO];
            end
        end
    end

    // Watchdog countdown in ticks
    always_comb
    begin
        count_d = count_q;
        dog_expire = 1'b0;
        if (mult_q == 6'h00)
        begin
            // Disabled: hold the counter at zero and raise nothing
            count_d = 6'h00;
        end
        else if (dog_strobe || (mult_d != mult_q))
        begin
            // Restart also on a new setting so the old count cannot fire early
            count_d = mult_d;
        end
        else if (tk.tick)
        begin
            if (count_q <= 6'h01)
            begin
                // Timeout after mult ticks, 31.25 ms each
                dog_expire = 1'b1;
                count_d = mult_q;
            end
            else
            begin
                count_d = count_q - 6'h01;
            end
        end
        if ((mult_q == 6'h00) && (mult_d != 6'h00))
        begin
            // Leaving the disabled state starts a full count
            count_d = mult_d;
        end
    end

    // Prescaler restart on strobe or new setting
    always_comb
    begin
        tk.restart = dog_strobe || (mult_d != mult_q);
    end

    // Interrupt control register
    always_comb
    begin
        intc_d = intc_q;
        if (i_wr && sel_int)
        begin
            intc_d = {i_wdata[7:2], 2'b00};
        end
    end

    // Sticky flags: set wins over the write-one clear
    always_comb
    begin
        events = 3'h0;
        events[`WDI_EV_DOG] = dog_expire;
        events[`WDI_EV_ALM] = i_alarm_match;
        events[`WDI_EV_PF] = i_powerfail;
        stat_d = stat_q;
        if (i_wr && sel_stat)
        begin
            stat_d = stat_q & ~i_wdata[2:0];
        end
        stat_d = stat_d | events;
    end

    // Mask register
    always_comb
    begin
        mask_d = mask_q;
        if (i_wr && sel_mask)
        begin
            mask_d = i_wdata[2:0];
        end
    end

    // Pin: only enabled and unmasked flags reach it
    always_comb
    begin
        enables = 3'h0;
        enables[`WDI_EV_DOG] = intc_q[`WDI_INT_DOG_EN];
        enables[`WDI_EV_ALM] = intc_q[`WDI_INT_ALM_EN];
        enables[`WDI_EV_PF] = intc_q[`WDI_INT_PF_EN];
        pin_active = |(stat_q & enables & mask_q);
        pin_mode = wdi_pkg::wdi_pin_t'(intc_q[`WDI_INT_POL]);
    end

    // Read mux; unmapped addresses read zero
    always_comb
    begin
        rdata_d = 8'h00;
        if (i_rd)
        begin
            if (sel_int)
            begin
                rdata_d = intc_q;
            end
            else if (sel_dog)
            begin
                // Strobe is write-only and reads back zero
                rdata_d = {1'b0, lock_q, mult_q};
            end
            else if (sel_stat)
            begin
                rdata_d = {5'h00, stat_q};
            end
            else if (sel_mask)
            begin
                rdata_d = {5'h00, mask_q};
            end
        end
    end

    // Register everything
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            intc_q <= `WDI_RST_INT;
            mult_q <= 6'h00;
            lock_q <= 1'b0;
            count_q <= 6'h00;
            stat_q <= 3'h0;
            mask_q <= `WDI_RST_MASK;
            rdata_q <= 8'h00;
        end
        else
        begin
            intc_q <= intc_d;
            mult_q <= mult_d;
            lock_q <= lock_d;
            count_q <= count_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            rdata_q <= rdata_d;
        end
    end

    // Outputs; open drain pulls low only, push-pull always drives
    always_comb
    begin
        o_rdata = rdata_q;
        o_irq = |(stat_q & mask_q);
        o_batt_alarm_en = intc_q[`WDI_INT_BATT];
        o_int_pulse_mode = intc_q[`WDI_INT_PULSE];
        if (pin_mode == wdi_pkg::WDI_PIN_PP)
        begin
            o_int_o = pin_active;
            o_int_oe = 1'b1;
        end
        else
        begin
            o_int_o = 1'b0;
            o_int_oe = pin_active;
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_arst_n);

    chk_strobe_reads_zero: assert property (i_rd && sel_dog |=> o_rdata[7] == 1'b0)
        else $error("Strobe bit read back as one");

    chk_lock_holds_mult: assert property (dog_wr && lock_q |=> $stable(mult_q))
        else $error("Multiplier changed while locked");

    chk_unlocked_load: assert property (dog_wr && !lock_q |=> mult_q == $past(i_wdata[5:0]))
        else $error("Unlocked write did not load multiplier");

    chk_zero_no_expire: assert property (mult_q == 6'h00 |-> !dog_expire)
        else $error("Expiry while watchdog disabled");

    chk_expire_on_tick: assert property (dog_expire |-> tk.tick && count_q <= 6'h01)
        else $error("Expiry not at end of count");

    chk_strobe_reload: assert property (dog_strobe && mult_q != 6'h00 && lock_q
        |=> count_q == $past(mult_q))
        else $error("Strobe did not reload count");

    chk_expire_flag: assert property (dog_expire |=> stat_q[`WDI_EV_DOG])
        else $error("Expiry did not set dog flag");

    chk_disabled_quiet: assert property (intc_q[7:5] == 3'h0 |-> !pin_active)
        else $error("Pin asserted with all sources disabled");

    chk_alarm_pin: assert property (i_alarm_match && intc_q[`WDI_INT_ALM_EN] && mask_q[`WDI_EV_ALM]
        && !(i_wr && sel_int) && !(i_wr && sel_mask) |=> pin_active)
        else $error("Enabled alarm did not reach pin");

    chk_pf_flag_only: assert property (i_powerfail |=> stat_q[`WDI_EV_PF])
        else $error("Power failure did not set flag");

    chk_od_polarity: assert property (pin_mode == wdi_pkg::WDI_PIN_OD |-> o_int_o == 1'b0
        && o_int_oe == pin_active)
        else $error("Open drain pin drove high");

    // Checked at the pins against the raw enable bits, so a wrong enable map shows up
    chk_pin_any_flag: assert property (pin_mode == wdi_pkg::WDI_PIN_PP
        |-> o_int_oe && o_int_o == |(stat_q & mask_q & intc_q[7:5]))
        else $error("Push-pull pin does not follow enabled flags");
endmodule

// ==== tb/wdi_host.sv ====
// Purpose: Host processor model that drives the register bus
// Assumes: One clock; the slave never stalls
// Notes: Idle address and data show the inverse of the last value
`include "wdi_defs.svh"
module wdi_host (
    input wire logic i_clk,
    output logic [16:0] o_addr,
    output logic [7:0] o_wdata,
    output logic o_wr,
    output logic o_rd,
    input wire logic [7:0] i_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // Quiet bus at time zero
    initial
    begin
        o_addr = '0;
        o_wdata = '0;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end

    // One-cycle write; a lock clear is always its own earlier write
    task automatic wr(input logic [16:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [16:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        @(negedge i_clk);
        d = i_rdata;
    endtask

    // Strobe with lock kept set, so the multiplier stays put
    task automatic kick();
        wr(`WDI_ADDR_DOG, 8'hC0);
    endtask
endmodule

// ==== tb/wdi_top_tb_top.sv ====
// Purpose: Self-checking bench for the watchdog and interrupt enables
// Assumes: Tick shortened to T cycles
// Notes: Register rows first, then events and watchdog by hand
`include "wdi_defs.svh"
module wdi_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned T = 20; // Short tick keeps the run brief
    typedef struct {logic [16:0] a; logic [7:0] d; logic [7:0] e;} wdi_row_t;
    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic i_alarm_match = 1'b0;
    logic i_powerfail = 1'b0;
    logic [16:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic o_irq;
    logic o_int_o;
    logic o_int_oe;
    logic o_batt_alarm_en;
    logic o_int_pulse_mode;
    int n_errors = 0;
    int checks = 0;
    int cyc = 0;
    int n;
    // Write, then expected read-back; reserved bits and the strobe read 0
    // Last row stops the watchdog so it cannot set flags during the event tests
    wdi_row_t rows [9] = '{
        '{`WDI_ADDR_DOG, 8'h00, 8'h00}, '{`WDI_ADDR_DOG, 8'h85, 8'h05},
        '{`WDI_ADDR_DOG, 8'h7F, 8'h7F}, '{`WDI_ADDR_DOG, 8'h01, 8'h3F},
        '{`WDI_ADDR_DOG, 8'h01, 8'h01}, '{`WDI_ADDR_INT, 8'hFF, 8'hFC},
        '{`WDI_ADDR_INT, 8'h00, 8'h00}, '{17'h1FFF0, 8'h5A, 8'h00},
        '{`WDI_ADDR_DOG, 8'h00, 8'h00}};

    always #5 i_clk = ~i_clk;

    wdi_host host (.i_clk(i_clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd), .i_rdata(rdata));

    wdi_top #(.TICK_CYC(T)) DUT (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_alarm_match(i_alarm_match), .i_powerfail(i_powerfail),
        .o_irq(o_irq), .o_int_o(o_int_o), .o_int_oe(o_int_oe), .o_batt_alarm_en(o_batt_alarm_en),
        .o_int_pulse_mode(o_int_pulse_mode));

    // Cut a hang short; the whole run needs about 600 cycles
    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: timeout", $time);
            end_of_test();
        end
    end

    task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
        checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask

    task automatic rdchk(input logic [16:0] a, input logic [7:0] e, input string m);
        logic [7:0] v;
        host.rd(a, v);
        chk(v, e, m);
    endtask

    // One-cycle event pulse: 1 alarm, 0 power fail
    task automatic pulse(input int s);
        @(posedge i_clk);
        if (s == 1)
            i_alarm_match <= 1'b1;
        else
            i_powerfail <= 1'b1;
        @(posedge i_clk);
        i_alarm_match <= 1'b0;
        i_powerfail <= 1'b0;
        @(negedge i_clk);
    endtask

    // Cycles until the level output rises, bounded
    task automatic wait_irq(output int c);
        c = 0;
        while (o_irq !== 1'b1 && c < 400)
        begin
            @(negedge i_clk);
            c++;
        end
    endtask

    task automatic end_of_test();
        $display("Counts: %0d checks, %0d mismatches", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (16) @(posedge i_clk);
        i_arst_n <= 1'b1;
        @(negedge i_clk);
        chk({7'h00, o_int_oe}, 8'h00, "pin idle");
        rdchk(`WDI_ADDR_MASK, 8'h07, "mask reset");
        rdchk(`WDI_ADDR_DOG, 8'h00, "dog reset");
        $display("test reset done");
        for (int i = 0; i < 9; i++)
        begin
            host.wr(rows[i].a, rows[i].d);
            rdchk(rows[i].a, rows[i].e, "row");
        end
        // Drop dog flags left by the running watchdog during the rows
        host.wr(`WDI_ADDR_STAT, 8'h07);
        $display("test rows done");
        // Stored control bits reach their outputs; push-pull always drives
        host.wr(`WDI_ADDR_INT, 8'h1C);
        @(negedge i_clk);
        chk({5'h00, o_batt_alarm_en, o_int_pulse_mode, o_int_oe}, 8'h07, "int bits");
        // Power fail and alarm, each with its enable off, then on
        for (int i = 0; i < 2; i++)
        begin
            host.wr(`WDI_ADDR_INT, 8'h08);
            pulse(i);
            rdchk(`WDI_ADDR_STAT, 8'h01 << i, "flag");
            chk({7'h00, o_int_o}, 8'h00, "pin off");
            host.wr(`WDI_ADDR_INT, 8'h08 | (8'h20 << i));
            @(negedge i_clk);
            chk({7'h00, o_int_o}, 8'h01, "pin on");
            host.wr(`WDI_ADDR_STAT, 8'h01 << i);
            @(negedge i_clk);
            chk({7'h00, o_int_o}, 8'h00, "pin clear");
        end
        host.wr(`WDI_ADDR_INT, 8'h40);
        pulse(1);
        chk({6'h00, o_int_oe, o_int_o}, 8'h02, "open drain");
        host.wr(`WDI_ADDR_STAT, 8'h02);
        @(negedge i_clk);
        chk({6'h00, o_int_oe, o_int_o}, 8'h00, "od release");
        // Mask gates both the level output and the pin
        host.wr(`WDI_ADDR_MASK, 8'h00);
        pulse(1);
        chk({6'h00, o_irq, o_int_oe}, 8'h00, "masked");
        host.wr(`WDI_ADDR_MASK, 8'h07);
        @(negedge i_clk);
        chk({6'h00, o_irq, o_int_oe}, 8'h03, "unmasked");
        host.wr(`WDI_ADDR_STAT, 8'h02);
        $display("test events done");
        // Watchdog timing, disable, strobe and silent expiry
        host.wr(`WDI_ADDR_INT, 8'h88);
        host.wr(`WDI_ADDR_DOG, 8'h00);
        host.wr(`WDI_ADDR_DOG, 8'h02);
        wait_irq(n);
        chk(8'((n >= 2 * T - 2) && (n <= 2 * T + 5)), 8'h01, "two ticks");
        chk({7'h00, o_int_o}, 8'h01, "dog pin");
        host.wr(`WDI_ADDR_DOG, 8'h00);
        host.wr(`WDI_ADDR_STAT, 8'h04);
        repeat (6 * T) @(negedge i_clk);
        chk({7'h00, o_irq}, 8'h00, "disabled");
        host.wr(`WDI_ADDR_DOG, 8'h43);
        for (int i = 0; i < 4; i++)
        begin
            repeat (2 * T) @(posedge i_clk);
            host.kick();
        end
        chk({7'h00, o_irq}, 8'h00, "kept alive");
        rdchk(`WDI_ADDR_DOG, 8'h43, "locked");
        wait_irq(n);
        chk(8'((n >= 3 * T - 8) && (n <= 3 * T + 5)), 8'h01, "three ticks");
        host.wr(`WDI_ADDR_INT, 8'h08);
        host.wr(`WDI_ADDR_STAT, 8'h04);
        @(negedge i_clk);
        wait_irq(n);
        chk({6'h00, o_irq, o_int_o}, 8'h02, "flag only");
        $display("test watchdog done");
        end_of_test();
    end
endmodule
